// ===== src/tmr16_defines.svh
// Offsets, field positions, reset values and divider counts of the timer control block
`ifndef TMR16_DEFINES_SVH
`define TMR16_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TMR16_ADDR_PORT3_DIR 16'hff23
`define TMR16_ADDR_MODE_CTRL 16'hff60
`define TMR16_ADDR_CLK_EDGE 16'hff61
`define TMR16_ADDR_CC_MODE 16'hff62
`define TMR16_ADDR_OUT_CTRL 16'hff63

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMR16_RST_PORT3_DIR 8'hff
`define TMR16_RST_MODE_CTRL 8'h00
`define TMR16_RST_CLK_EDGE 8'h00
`define TMR16_RST_CC_MODE 8'h00
`define TMR16_RST_OUT_CTRL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR16_MODE_OVF_BIT 0
`define TMR16_MODE_LO 1
`define TMR16_MODE_HI 3
`define TMR16_CCM_A_MODE_BIT 0
`define TMR16_CCM_A_TRIG_BIT 1
`define TMR16_CCM_B_MODE_BIT 2
`define TMR16_OC_TOE_BIT 0
`define TMR16_OC_INV_A_BIT 1
`define TMR16_OC_LVR_BIT 2
`define TMR16_OC_LVS_BIT 3
`define TMR16_OC_INV_B_BIT 4
`define TMR16_OC_OSPE_BIT 5
`define TMR16_OC_OSPT_BIT 6
`define TMR16_CE_CLK_LO 0
`define TMR16_CE_CLK_HI 1
`define TMR16_CE_EDGE_A_LO 4
`define TMR16_CE_EDGE_A_HI 5
`define TMR16_CE_EDGE_B_LO 6
`define TMR16_CE_EDGE_B_HI 7
`define TMR16_P3_DIR_LO 0
`define TMR16_P3_DIR_HI 1

// ----------------------------------------------------------------
// Readable masks and fixed bits
// ----------------------------------------------------------------
`define TMR16_OC_STORE_MASK 8'h33
`define TMR16_P3_FIXED_ONES 8'hfc

// ----------------------------------------------------------------
// Prescaler tap masks: divide by 4 and by 256
// ----------------------------------------------------------------
`define TMR16_DIV4_MASK 8'h03
`define TMR16_DIV256_MASK 8'hff
`define TMR16_CNT_MAX 16'hffff

`endif

// ===== src/tmr16_pkg.sv
// Types shared by the timer control block
`default_nettype none
package tmr16_pkg;
	typedef enum logic [1:0] {
		OPM_STOP = 2'h0,
		OPM_FREE = 2'h1,
		OPM_CLR_EDGE = 2'h2,
		OPM_CLR_MATCH = 2'h3
	} tmr16_opmode_t;

	typedef enum logic [1:0] {
		CKS_FXP = 2'h0,
		CKS_DIV4 = 2'h1,
		CKS_DIV256 = 2'h2,
		CKS_EXT = 2'h3
	} tmr16_clksel_t;

	typedef enum logic [1:0] {
		EDG_FALL = 2'h0,
		EDG_RISE = 2'h1,
		EDG_BAD = 2'h2,
		EDG_BOTH = 2'h3
	} tmr16_edge_t;

	typedef enum logic [0:0] {
		OS_IDLE = 1'b0,
		OS_ARMED = 1'b1
	} tmr16_os_state_t;
endpackage
`default_nettype wire

// ===== src/tmr16_edge_det.sv
// Pin synchroniser, two-sample noise filter and edge detector for one timer input
`default_nettype none
module tmr16_edge_det (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Pin and control
	input wire logic pin,
	input wire logic sample_en,
	input wire logic track_en,
	input wire logic [1:0] edge_sel,
	// Edges
	output logic rise,
	output logic fall,
	output logic valid_edge
);
	logic sync1_r;
	logic sync2_r;
	logic samp_r;
	logic lvl_r;
	logic prev_r;

	// A level is accepted only after two equal samples, so short glitches are dropped
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			samp_r <= 1'b0;
			lvl_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			sync1_r <= pin;
			sync2_r <= sync1_r;
			if (sample_en) begin
				samp_r <= sync2_r;
				if (samp_r == sync2_r)
					lvl_r <= sync2_r;
			end
			// RULE_22 - reference level frozen until first run
			if (track_en)
				prev_r <= lvl_r;
		end
	end

	assign rise = track_en & lvl_r & ~prev_r;
	assign fall = track_en & ~lvl_r & prev_r;
	assign valid_edge = (edge_sel == tmr16_pkg::EDG_FALL) ? fall :
		(edge_sel == tmr16_pkg::EDG_RISE) ? rise :
		(edge_sel == tmr16_pkg::EDG_BOTH) ? (rise | fall) : 1'b0;
endmodule
`default_nettype wire

// ===== src/tmr16_ctrl.sv
// Control, output and capture logic of the 16-bit timer with two capture/compare registers
//
// Operation
// RULE_01 - Wrap at FFFFH with A=FFFFH sets overflow
// RULE_02 - Overflow flag stays until software clears
// RULE_03 - Stop timer before changing mode register
// RULE_04 - B mode bit: compare or capture
// RULE_05 - A trigger: input B or opposite input A
// RULE_06 - A mode bit: compare or capture
// RULE_07 - Stop first; no A capture with clear-on-match
// RULE_08 - Both edges on A: no opposite capture
// RULE_09 - Capture pulse longer than two count clocks
// RULE_10 - Soft trigger fires pulse, self-clears, reads zero
// RULE_11 - One-shot only in free-run or edge-clear
// RULE_12 - B match toggles output when enabled
// RULE_13 - A match toggles output when enabled
// RULE_14 - Set/reset pair forces output, reads zero
// RULE_15 - Output disabled holds pin low
// RULE_16 - Stop first; trigger spacing two count clocks
// RULE_17 - Edge select for input B
// RULE_18 - Edge select for input A
// RULE_19 - Count clock: fxp, /4, /256, input A
// RULE_20 - External count pulse above two fxp cycles
// RULE_21 - Stop first; no double use of input A
// RULE_22 - High input after reset gives one rise
// RULE_23 - Direction bits choose timer output or inputs
`include "tmr16_defines.svh"
`default_nettype none
module tmr16_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Byte register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Capture/compare word port
	input wire logic cc_wr_a,
	input wire logic cc_wr_b,
	input wire logic [15:0] cc_wdata,
	output logic [15:0] counter_value,
	output logic [15:0] cca_value,
	output logic [15:0] ccb_value,
	// Timer pins
	input wire logic timer_input_a_pin,
	input wire logic shared_pin_in,
	output logic shared_pin_out,
	output logic shared_pin_oe
);
	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] base);
		reg_hit = (addr == base);
	endfunction

	logic [7:0] port3_direction_r;
	logic [2:0] mode_r;
	logic overflow_flag_r;
	logic [7:0] timer_clock_edge_select_r;
	logic [2:0] capture_compare_mode_control_r;
	logic [7:0] timer_output_control_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_mux;

	wire wr_p3 = reg_wr & reg_hit(reg_addr, `TMR16_ADDR_PORT3_DIR);
	wire wr_mode = reg_wr & reg_hit(reg_addr, `TMR16_ADDR_MODE_CTRL);
	wire wr_ce = reg_wr & reg_hit(reg_addr, `TMR16_ADDR_CLK_EDGE);
	wire wr_ccm = reg_wr & reg_hit(reg_addr, `TMR16_ADDR_CC_MODE);
	wire wr_oc = reg_wr & reg_hit(reg_addr, `TMR16_ADDR_OUT_CTRL);

	// ----------------------------------------------------------------
	// Field views
	// ----------------------------------------------------------------
	tmr16_pkg::tmr16_opmode_t opmode;
	tmr16_pkg::tmr16_clksel_t clock_select;
	logic [1:0] edge_a_select;
	logic [1:0] edge_b_select;
	assign opmode = tmr16_pkg::tmr16_opmode_t'(mode_r[2:1]);
	assign clock_select = tmr16_pkg::tmr16_clksel_t'(
		timer_clock_edge_select_r[`TMR16_CE_CLK_HI:`TMR16_CE_CLK_LO]);
	assign edge_a_select = timer_clock_edge_select_r[`TMR16_CE_EDGE_A_HI:`TMR16_CE_EDGE_A_LO];
	assign edge_b_select = timer_clock_edge_select_r[`TMR16_CE_EDGE_B_HI:`TMR16_CE_EDGE_B_LO];

	wire edge_invert_en = mode_r[0];
	wire cca_mode_select = capture_compare_mode_control_r[`TMR16_CCM_A_MODE_BIT];
	wire cca_trigger_select = capture_compare_mode_control_r[`TMR16_CCM_A_TRIG_BIT];
	wire ccb_mode_select = capture_compare_mode_control_r[`TMR16_CCM_B_MODE_BIT];
	wire output_enable_bit = timer_output_control_r[`TMR16_OC_TOE_BIT];
	wire invert_on_a_match = timer_output_control_r[`TMR16_OC_INV_A_BIT];
	wire invert_on_b_match = timer_output_control_r[`TMR16_OC_INV_B_BIT];
	wire oneshot_enable = timer_output_control_r[`TMR16_OC_OSPE_BIT];
	wire shared_pin_direction = port3_direction_r[`TMR16_P3_DIR_HI];

	wire running = (opmode != tmr16_pkg::OPM_STOP);
	wire mode_clr_edge = (opmode == tmr16_pkg::OPM_CLR_EDGE);
	wire mode_clr_match = (opmode == tmr16_pkg::OPM_CLR_MATCH);

	// ----------------------------------------------------------------
	// Prescaler and count clock
	// ----------------------------------------------------------------
	logic [7:0] presc_r;
	logic has_run_r;
	logic ti_a_rise;
	logic ti_a_fall;
	logic ti_a_valid;
	logic ti_b_valid;

	// RULE_19 - internal tap selection
	wire presc_tick = (clock_select == tmr16_pkg::CKS_FXP) ? 1'b1 :
		(clock_select == tmr16_pkg::CKS_DIV4) ?
			((presc_r & `TMR16_DIV4_MASK) == `TMR16_DIV4_MASK) :
		(clock_select == tmr16_pkg::CKS_DIV256) ?
			((presc_r & `TMR16_DIV256_MASK) == `TMR16_DIV256_MASK) : 1'b0;
	// RULE_19 - input A edge as count clock
	wire tick = running & ((clock_select == tmr16_pkg::CKS_EXT) ? ti_a_valid : presc_tick);
	// External clock is filtered at fxp; capture inputs at the count clock rate
	wire sample_tick = (clock_select == tmr16_pkg::CKS_EXT) ? 1'b1 : presc_tick;
	wire track_en = running | has_run_r;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			presc_r <= 8'h00;
			has_run_r <= 1'b0;
		end else begin
			presc_r <= running ? presc_r + 8'h01 : 8'h00;
			has_run_r <= has_run_r | running;
		end
	end

	// ----------------------------------------------------------------
	// Input edge detection
	// ----------------------------------------------------------------
	// RULE_18 - input A edge choice
	tmr16_edge_det u_edge_a (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin(timer_input_a_pin),
		.sample_en(sample_tick),
		.track_en(track_en),
		.edge_sel(edge_a_select),
		.rise(ti_a_rise),
		.fall(ti_a_fall),
		.valid_edge(ti_a_valid)
	);

	// RULE_17 - input B edge choice
	tmr16_edge_det u_edge_b (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin(shared_pin_in),
		.sample_en(sample_tick),
		.track_en(track_en),
		.edge_sel(edge_b_select),
		.rise(),
		.fall(),
		.valid_edge(ti_b_valid)
	);

	// ----------------------------------------------------------------
	// Counter, compare and capture
	// ----------------------------------------------------------------
	logic [15:0] cnt_r;
	logic [15:0] cca_r;
	logic [15:0] ccb_r;
	logic [15:0] cnt_nxt;

	wire match_a = tick & ~cca_mode_select & (cnt_r == cca_r);
	wire match_b = tick & ~ccb_mode_select & (cnt_r == ccb_r);
	wire edge_a_event = running & ti_a_valid;
	// RULE_08 - opposite phase, none for both edges
	wire ti_a_opposite = (edge_a_select == tmr16_pkg::EDG_RISE) ? ti_a_fall :
		(edge_a_select == tmr16_pkg::EDG_FALL) ? ti_a_rise : 1'b0;
	// RULE_05 - A capture trigger source
	wire cca_trig = running & cca_mode_select & (cca_trigger_select ? ti_a_opposite : ti_b_valid);
	// RULE_04 - B capture on input A edge
	wire ccb_trig = running & ccb_mode_select & edge_a_event;
	// RULE_11 - one-shot only outside clear-on-match
	wire oneshot_ok = oneshot_enable & running & ~mode_clr_match;
	// RULE_10 - write of the trigger bit fires
	wire soft_fire = wr_oc & reg_wdata[`TMR16_OC_OSPT_BIT] & oneshot_ok;
	wire edge_fire = oneshot_ok & mode_clr_edge & edge_a_event;
	// RULE_01 - wrap with A at all ones
	wire ovf_set = tick & (cnt_r == `TMR16_CNT_MAX) & (cca_r == `TMR16_CNT_MAX);

	always_comb begin
		cnt_nxt = cnt_r;
		if (!running)
			cnt_nxt = 16'h0000;
		else if (soft_fire | (mode_clr_edge & edge_a_event))
			cnt_nxt = 16'h0000;
		else if (tick)
			cnt_nxt = (mode_clr_match & match_a) ? 16'h0000 : cnt_r + 16'h0001;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_r <= 16'h0000;
			cca_r <= 16'h0000;
			ccb_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_nxt;
			// RULE_06 - capture wins over a software write
			if (cca_trig)
				cca_r <= cnt_r;
			else if (cc_wr_a)
				cca_r <= cc_wdata;
			if (ccb_trig)
				ccb_r <= cnt_r;
			else if (cc_wr_b)
				ccb_r <= cc_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Output flip-flop and one-shot sequencer
	// ----------------------------------------------------------------
	tmr16_pkg::tmr16_os_state_t os_state_r;
	tmr16_pkg::tmr16_os_state_t os_state_nxt;
	logic out_ff_r;
	logic out_ff_nxt;

	wire lv_set = wr_oc & reg_wdata[`TMR16_OC_LVS_BIT] & ~reg_wdata[`TMR16_OC_LVR_BIT];
	wire lv_reset = wr_oc & ~reg_wdata[`TMR16_OC_LVS_BIT] & reg_wdata[`TMR16_OC_LVR_BIT];
	// RULE_12 - B match inversion term
	wire inv_b = match_b & invert_on_b_match;
	// RULE_13 - A match inversion term
	wire inv_a = match_a & invert_on_a_match;
	wire inv_edge = edge_a_event & edge_invert_en;

	always_comb begin
		os_state_nxt = os_state_r;
		unique case (os_state_r)
			tmr16_pkg::OS_IDLE: begin
				if (soft_fire | edge_fire)
					os_state_nxt = tmr16_pkg::OS_ARMED;
			end
			tmr16_pkg::OS_ARMED: begin
				if (!oneshot_ok | match_a)
					os_state_nxt = tmr16_pkg::OS_IDLE;
			end
		endcase
	end

	always_comb begin
		out_ff_nxt = out_ff_r;
		// RULE_14 - software set/reset has priority
		if (lv_reset)
			out_ff_nxt = 1'b0;
		else if (lv_set)
			out_ff_nxt = 1'b1;
		else if (oneshot_enable) begin
			if (oneshot_ok & (os_state_r == tmr16_pkg::OS_ARMED)) begin
				if (match_a)
					out_ff_nxt = 1'b0;
				else if (match_b)
					out_ff_nxt = 1'b1;
			end
		end else if (running)
			out_ff_nxt = out_ff_r ^ inv_a ^ inv_b ^ inv_edge;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			os_state_r <= tmr16_pkg::OS_IDLE;
			out_ff_r <= 1'b0;
		end else begin
			os_state_r <= os_state_nxt;
			out_ff_r <= out_ff_nxt;
		end
	end

	// RULE_15 - disabled output forced low
	assign shared_pin_out = output_enable_bit & out_ff_r;
	// RULE_23 - direction bit zero drives the pin
	assign shared_pin_oe = ~shared_pin_direction;

	// ----------------------------------------------------------------
	// Register storage and readback
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			port3_direction_r <= `TMR16_RST_PORT3_DIR;
			mode_r <= 3'h0;
			overflow_flag_r <= 1'b0;
			timer_clock_edge_select_r <= `TMR16_RST_CLK_EDGE;
			capture_compare_mode_control_r <= 3'h0;
			timer_output_control_r <= `TMR16_RST_OUT_CTRL;
			rdata_r <= 8'h00;
		end else begin
			if (wr_p3)
				port3_direction_r <= reg_wdata | `TMR16_P3_FIXED_ONES;
			if (wr_mode)
				mode_r <= reg_wdata[`TMR16_MODE_HI:`TMR16_MODE_LO];
			// RULE_02 - set wins over a clearing write
			overflow_flag_r <= ovf_set |
				(wr_mode ? reg_wdata[`TMR16_MODE_OVF_BIT] : overflow_flag_r);
			if (wr_ce)
				timer_clock_edge_select_r <= reg_wdata & 8'hf3;
			if (wr_ccm)
				capture_compare_mode_control_r <= reg_wdata[2:0];
			// RULE_10 - trigger and set/reset bits are never stored
			if (wr_oc)
				timer_output_control_r <= reg_wdata & `TMR16_OC_STORE_MASK;
			if (reg_rd)
				rdata_r <= rd_mux;
		end
	end

	assign rd_mux = reg_hit(reg_addr, `TMR16_ADDR_PORT3_DIR) ? port3_direction_r :
		reg_hit(reg_addr, `TMR16_ADDR_MODE_CTRL) ? {4'h0, mode_r, overflow_flag_r} :
		reg_hit(reg_addr, `TMR16_ADDR_CLK_EDGE) ? timer_clock_edge_select_r :
		reg_hit(reg_addr, `TMR16_ADDR_CC_MODE) ? {5'h00, capture_compare_mode_control_r} :
		reg_hit(reg_addr, `TMR16_ADDR_OUT_CTRL) ? timer_output_control_r : 8'h00;

	assign reg_rdata = rdata_r;
	assign counter_value = cnt_r;
	assign cca_value = cca_r;
	assign ccb_value = ccb_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ovf_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
		(tick && cnt_r == 16'hffff && cca_r == 16'hffff) |=> (overflow_flag_r && cnt_r == 16'h0000))
		else $error("overflow not set on wrap");
	a_ovf_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
		(overflow_flag_r && !wr_mode) |=> overflow_flag_r)
		else $error("overflow flag dropped without write");
	a_ccb_capture: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
		(running && ccb_mode_select && ti_a_valid) |=> (ccb_r == $past(cnt_r)))
		else $error("B capture missed");
	a_cca_from_b: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_05
		(running && cca_mode_select && !cca_trigger_select && ti_b_valid)
		|=> (cca_r == $past(cnt_r)))
		else $error("A capture from input B missed");
	a_no_opp_both: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
		(cca_mode_select && cca_trigger_select && edge_a_select == 2'h3 && !cc_wr_a)
		|=> $stable(cca_r))
		else $error("opposite capture with both edges");
	a_toc_reads: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_10
		(reg_rd && reg_addr == 16'hff63) |=> (reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'h0))
		else $error("self-clearing bits read nonzero");
	a_inv_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_13
		(running && !oneshot_enable && !wr_oc && inv_a && !inv_b && !inv_edge)
		|=> (out_ff_r != $past(out_ff_r)))
		else $error("A match did not toggle output");
	a_inv_b: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_12
		(running && !oneshot_enable && !wr_oc && inv_b && !inv_a && !inv_edge)
		|=> (out_ff_r != $past(out_ff_r)))
		else $error("B match did not toggle output");
	a_lv_force: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_14
		(reg_wr && reg_addr == 16'hff63 && reg_wdata[3:2] == 2'h2) |=> out_ff_r)
		else $error("output set write ignored");
	a_pin_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
		!output_enable_bit |-> (shared_pin_out == 1'b0))
		else $error("disabled output not low");
	a_div4_tick: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_19
		(running && clock_select == tmr16_pkg::CKS_DIV4 && tick) |=> !tick [*3])
		else $error("divide by four tick spacing wrong");
	a_oneshot_mode: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_11
		mode_clr_match |=> (os_state_r == tmr16_pkg::OS_IDLE))
		else $error("one-shot armed in clear-on-match");
endmodule
`default_nettype wire

// ===== test/tmr16_pulse_src.sv
// Behavioural pulse source standing in for the signals on both timer input pins
`default_nettype none
module tmr16_pulse_src (
	// Clock
	input wire logic sys_clk,
	// Timer input pins
	output logic pin_a,
	output logic pin_b
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		pin_a = 1'h0;
		pin_b = 1'h0;
	end

	// ----------------------------------------------------------------
	// Pulse generation
	// ----------------------------------------------------------------
	// width floor
	// Width counts in fxp cycles, so it only exceeds two count clocks at fxp rate
	task automatic pulse(input logic to_b, input int width);
		int w;
		w = (width < 3) ? 3 : width;
		@(negedge sys_clk);
		if (to_b) begin
			pin_b = 1'h1;
		end else begin
			pin_a = 1'h1;
		end
		repeat (w) @(negedge sys_clk);
		pin_a = 1'h0;
		pin_b = 1'h0;
		repeat (w) @(negedge sys_clk);
	endtask

	// Holds input A at a level, for the reset and edge-clear tests
	task automatic hold(input logic v);
		@(negedge sys_clk);
		pin_a = v;
	endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the timer control block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk, rst_n, reg_wr, reg_rd, cc_wr_a, cc_wr_b;
	logic [15:0] reg_addr, cc_wdata, counter_value, cca_value, ccb_value, v0;
	logic [7:0] reg_wdata, reg_rdata;
	logic pin_a, pin_b, pin_out, pin_oe, shared_w;
	int failures, comparisons, cyc, s, d;
	int sh[3] = '{0, 2, 8};
	logic [7:0] ext[3] = '{8'h03, 8'h13, 8'h33};
	int ext_n[3] = '{3, 3, 6};

	// Wire level of the shared pin from both parties
	assign shared_w = pin_oe ? pin_out : pin_b;

	tmr16_ctrl i_tmr16_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.cc_wr_a(cc_wr_a), .cc_wr_b(cc_wr_b), .cc_wdata(cc_wdata),
		.counter_value(counter_value), .cca_value(cca_value), .ccb_value(ccb_value),
		.timer_input_a_pin(pin_a), .shared_pin_in(shared_w), .shared_pin_out(pin_out),
		.shared_pin_oe(pin_oe));
	tmr16_pulse_src i_tmr16_pulse_src (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));

	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) cyc <= cyc + 1;

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] dt);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = dt;
		reg_wr = 1'h1;
		@(negedge sys_clk);
		reg_wr = 1'h0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge sys_clk);
		reg_rd = 1'h0;
		check({8'h00, reg_rdata}, {8'h00, exp});
	endtask

	task automatic ccw(input logic b, input logic [15:0] dt);
		@(negedge sys_clk);
		cc_wdata = dt;
		cc_wr_a = !b;
		cc_wr_b = b;
		@(negedge sys_clk);
		cc_wr_a = 1'h0;
		cc_wr_b = 1'h0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Stop, select clock and edges, then start free-running
	// stop before writing
	task automatic run(input logic [7:0] cks);
		wr(16'hff60, 8'h00);
		wr(16'hff61, cks);
		wr(16'hff60, 8'h04);
		s = cyc;
	endtask

	task automatic end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Tests need about 70000 cycles
	initial begin
		repeat (90000) @(posedge sys_clk);
		failures++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		cc_wr_a = 1'h0;
		cc_wr_b = 1'h0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		cc_wdata = 16'h0000;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'h1;
		rd(16'hff23, 8'hff);
		rd(16'hff60, 8'h00);
		rd(16'hff61, 8'h00);
		rd(16'hff62, 8'h00);
		rd(16'hff63, 8'h00);
		rd(16'hff64, 8'h00);
		check(pin_oe, 16'h0000);
		wr(16'hff63, 8'h08);
		check(pin_out, 16'h0000);
		wr(16'hff23, 8'hfd);
		rd(16'hff23, 8'hfd);
		check(pin_oe, 16'h0001);
		wr(16'hff63, 8'h09);
		check(pin_out, 16'h0001);
		rd(16'hff63, 8'h01);
		wr(16'hff63, 8'h05);
		check(pin_out, 16'h0000);
		ccw(1'h0, 16'h0010);
		ccw(1'h1, 16'h0020);
		wr(16'hff63, 8'h07);
		run(8'h00);
		idle(8);
		check(pin_out, 16'h0000);
		idle(16);
		check(pin_out, 16'h0001);
		idle(12);
		check(pin_out, 16'h0001);
		wr(16'hff60, 8'h00);
		wr(16'hff63, 8'h15);
		run(8'h00);
		idle(24);
		check(pin_out, 16'h0000);
		idle(16);
		check(pin_out, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			run(8'(i));
			idle(2);
			v0 = counter_value;
			idle(512);
			check(counter_value - v0, 16'(512 >> sh[i]));
		end
		for (int i = 0; i < 3; i++) begin
			run(ext[i]);
			idle(4);
			v0 = counter_value;
			repeat (3) i_tmr16_pulse_src.pulse(1'h0, 6);
			idle(8);
			check(counter_value - v0, 16'(ext_n[i]));
		end
		wr(16'hff60, 8'h00);
		wr(16'hff23, 8'hff);
		ccw(1'h0, 16'h1234);
		ccw(1'h1, 16'h1234);
		wr(16'hff62, 8'h05);
		run(8'h50);
		idle(20);
		d = cyc - s;
		i_tmr16_pulse_src.pulse(1'h1, 6);
		check(16'(cca_value >= d - 1 && cca_value <= d + 8), 16'h0001);
		d = cyc - s;
		i_tmr16_pulse_src.pulse(1'h0, 6);
		check(16'(ccb_value >= d - 1 && ccb_value <= d + 8), 16'h0001);
		wr(16'hff60, 8'h00);
		wr(16'hff62, 8'h03);
		ccw(1'h0, 16'h1234);
		run(8'h30);
		idle(8);
		i_tmr16_pulse_src.pulse(1'h0, 6);
		idle(6);
		check(cca_value, 16'h1234);
		wr(16'hff60, 8'h00);
		wr(16'hff62, 8'h00);
		wr(16'hff63, 8'h20);
		wr(16'hff60, 8'h04);
		wr(16'hff63, 8'h60);
		rd(16'hff63, 8'h20);
		ccw(1'h0, 16'hffff);
		run(8'h00);
		idle(65545);
		rd(16'hff60, 8'h05);
		idle(10);
		rd(16'hff60, 8'h05);
		wr(16'hff60, 8'h04);
		rd(16'hff60, 8'h04);
		wr(16'hff60, 8'h00);
		ccw(1'h0, 16'h0009);
		wr(16'hff60, 8'h0c);
		wr(16'hff63, 8'h60);
		idle(23);
		check(counter_value, 16'h0005);
		// high input across a second reset
		i_tmr16_pulse_src.hold(1'h1);
		@(negedge sys_clk);
		rst_n = 1'h0;
		idle(2);
		rst_n = 1'h1;
		rd(16'hff61, 8'h00);
		rd(16'hff62, 8'h00);
		run(8'h13);
		idle(4);
		check(counter_value, 16'h0001);
		run(8'h13);
		idle(4);
		check(counter_value, 16'h0000);
		wr(16'hff60, 8'h00);
		wr(16'hff61, 8'h00);
		wr(16'hff60, 8'h08);
		i_tmr16_pulse_src.hold(1'h0);
		idle(9);
		check(counter_value, 16'h0004);
		end_sim();
	end
endmodule
`default_nettype wire
